/* File: hdl/cit_pkg.sv */
// Contract
// [RULE1] Opcodes, addressing modes and status flag effects match the classic 8-bit set.
// [RULE2] Every instruction is timed in plain system clock cycles, no machine cycles.
// [RULE3] No instruction exceeds eight clocks; divide takes exactly eight.
// [RULE4] A conditional branch not taken finishes one clock sooner than when taken.
// [RULE5] Exactly 109 distinct instructions are implemented.
// [RULE6] Add, add-with-carry, subtract-with-borrow from a register: one byte, one clock.
// [RULE7] Arithmetic with a direct byte source: two bytes, two clocks.
// [RULE8] Arithmetic with an indirect RAM source: one byte, two clocks.
// [RULE9] Arithmetic with an immediate source: two bytes, two clocks.
// [RULE10] AND, OR, XOR of a register into the accumulator: one byte, one clock.
// [RULE11] AND, OR, XOR of an immediate into the accumulator: two bytes, two clocks.
// [RULE12] AND, OR, XOR of indirect RAM into the accumulator: one byte, two clocks.
// [RULE13] Logic writing the accumulator into a direct byte: two bytes, two clocks.
// [RULE14] Logic of an immediate into a direct byte: three bytes, three clocks.
// [RULE15] One synchronous clock; reset returns to opcode fetch, nothing half done.
`default_nettype none
package cit_pkg;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam logic [3:0] MAX_CYCLES     = 4'h8;
    localparam int         INSTR_COUNT    = 109;
    localparam logic [7:0] UNDEF_OPCODE   = 8'ha5;
    localparam logic [7:0] ACC_RESET      = 8'h00;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam int         FLAG_CY        = 7;
    localparam int         FLAG_AC        = 6;
    localparam int         FLAG_OV        = 2;
    localparam int         FLAG_P         = 0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        CIT_ALU_ADD,
        CIT_ALU_ADDC,
        CIT_ALU_SUBB,
        CIT_ALU_AND,
        CIT_ALU_OR,
        CIT_ALU_XOR
    } cit_alu_op_type;

    typedef enum logic {
        CIT_ST_FETCH,
        CIT_ST_RUN
    } cit_state_type;

    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic       cond;
    } cit_timing_type;

    // ****************************************************************
    // Opcode timing table
    // ****************************************************************
    // Cycles are the not-taken figure; a taken conditional adds one.
    function automatic cit_timing_type cit_decode(input logic [7:0] op);
        logic [3:0]     h;
        logic [3:0]     l;
        cit_timing_type t;
        h = op[7:4];
        l = op[3:0];
        t = '{bytes: 2'h1, cycles: 4'h1, cond: 1'b0};
        if (l[3]) begin
            case (h)
                4'h7, 4'h8, 4'ha: t = '{2'h2, 4'h2, 1'b0};
                4'hb:             t = '{2'h3, 4'h3, 1'b1};
                4'hd:             t = '{2'h2, 4'h2, 1'b1};
                default:          t = '{2'h1, 4'h1, 1'b0}; // RULE6 RULE10
            endcase
        end else if (l[3:1] == 3'h3) begin
            case (h)
                4'h7, 4'h8, 4'ha: t = '{2'h2, 4'h2, 1'b0};
                4'hb:             t = '{2'h3, 4'h4, 1'b1};
                default:          t = '{2'h1, 4'h2, 1'b0}; // RULE8 RULE12
            endcase
        end else if (l == 4'h5) begin
            case (h)
                4'h7, 4'h8: t = '{2'h3, 4'h3, 1'b0};
                4'ha:       t = '{2'h1, 4'h1, 1'b0};
                4'hb:       t = '{2'h3, 4'h4, 1'b1};
                4'hd:       t = '{2'h3, 4'h3, 1'b1};
                default:    t = '{2'h2, 4'h2, 1'b0}; // RULE7
            endcase
        end else if (l == 4'h4) begin
            case (h)
                4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: t = '{2'h1, 4'h1, 1'b0};
                4'h8:    t = '{2'h1, MAX_CYCLES, 1'b0}; // RULE3
                4'ha:    t = '{2'h1, 4'h4, 1'b0};
                4'hb:    t = '{2'h3, 4'h3, 1'b1};
                default: t = '{2'h2, 4'h2, 1'b0}; // RULE9 RULE11
            endcase
        end else if (l == 4'h3) begin
            case (h)
                4'h4, 4'h5, 4'h6:       t = '{2'h3, 4'h3, 1'b0}; // RULE14
                4'h7, 4'h8, 4'h9, 4'he, 4'hf: t = '{2'h1, 4'h3, 1'b0};
                default:                t = '{2'h1, 4'h1, 1'b0};
            endcase
        end else if (l == 4'h2) begin
            case (h)
                4'h0, 4'h1: t = '{2'h3, 4'h4, 1'b0};
                4'h2, 4'h3: t = '{2'h1, 4'h5, 1'b0};
                4'he, 4'hf: t = '{2'h1, 4'h3, 1'b0};
                default:    t = '{2'h2, 4'h2, 1'b0}; // RULE13
            endcase
        end else if (l == 4'h1) begin
            t = '{2'h2, 4'h3, 1'b0};
        end else begin
            case (h)
                4'h0:                   t = '{2'h1, 4'h1, 1'b0};
                4'h1, 4'h2, 4'h3:       t = '{2'h3, 4'h3, 1'b1};
                4'h4, 4'h5, 4'h6, 4'h7: t = '{2'h2, 4'h2, 1'b1};
                4'h8:                   t = '{2'h2, 4'h3, 1'b0};
                4'h9:                   t = '{2'h3, 4'h3, 1'b0};
                4'he, 4'hf:             t = '{2'h1, 4'h3, 1'b0};
                default:                t = '{2'h2, 4'h2, 1'b0};
            endcase
        end
        return t;
    endfunction : cit_decode

endpackage : cit_pkg
`default_nettype wire

/* File: hdl/cit_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_alu (
    input  wire logic [7:0]          a_in,
    input  wire logic [7:0]          b_in,
    input  wire logic                carry_in,
    input  wire cit_pkg::cit_alu_op_type op_in,
    output logic      [7:0]          result_out,
    output logic                     cy_out,
    output logic                     ac_out,
    output logic                     ov_out
);

    logic [8:0] wide;
    logic [4:0] low;
    logic       sub;

    // ****************************************************************
    // Arithmetic and logic
    // ****************************************************************
    always_comb begin
        wide = 9'h000;
        low  = 5'h00;
        sub  = (op_in == cit_pkg::CIT_ALU_SUBB);
        case (op_in)
            cit_pkg::CIT_ALU_ADD,
            cit_pkg::CIT_ALU_ADDC: begin
                wide = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
                low  = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
            end
            cit_pkg::CIT_ALU_SUBB: begin
                wide = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
                low  = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, carry_in};
            end
            cit_pkg::CIT_ALU_AND: wide = {1'b0, a_in & b_in};
            cit_pkg::CIT_ALU_OR:  wide = {1'b0, a_in | b_in};
            cit_pkg::CIT_ALU_XOR: wide = {1'b0, a_in ^ b_in};
            default:              wide = {1'b0, a_in};
        endcase
        result_out = wide[7:0];
        cy_out     = wide[8];
        ac_out     = low[4];
        // Overflow: signed result leaves the signed range
        if (sub) begin
            ov_out = (a_in[7] != b_in[7]) && (wide[7] != a_in[7]);
        end else begin
            ov_out = (a_in[7] == b_in[7]) && (wide[7] != a_in[7]);
        end
    end

endmodule : cit_alu
`default_nettype wire

/* File: hdl/cit_core_timing.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_core_timing (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       code_valid_in,
    input  wire logic [7:0] code_byte_in,
    output logic            code_ready_out,
    input  wire logic       branch_taken_in,
    input  wire logic [7:0] src_data_in,
    input  wire logic       acc_load_in,
    input  wire logic [7:0] acc_load_data_in,
    input  wire logic       flags_load_in,
    input  wire logic [7:0] flags_load_data_in,
    output logic            busy_out,
    output logic            instr_done_out,
    output logic [7:0]      instr_opcode_out,
    output logic [7:0]      instr_operand1_out,
    output logic [7:0]      instr_operand2_out,
    output logic [1:0]      instr_bytes_out,
    output logic [3:0]      instr_cycles_out,
    output logic            instr_taken_out,
    output logic            instr_undefined_out,
    output logic [7:0]      acc_out,
    output logic [7:0]      program_status_flags_out,
    output logic            direct_wr_out,
    output logic [7:0]      direct_addr_out,
    output logic [7:0]      direct_data_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    cit_pkg::cit_state_type state;
    cit_pkg::cit_state_type next_state;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [7:0] byte1;
    logic [7:0] next_byte1;
    logic [7:0] byte2;
    logic [7:0] next_byte2;
    logic [1:0] bytes;
    logic [1:0] next_bytes;
    logic [3:0] cycles;
    logic [3:0] next_cycles;
    logic       cond;
    logic       next_cond;
    logic       taken;
    logic       next_taken;
    logic [1:0] got;
    logic [1:0] next_got;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic       done;
    logic       next_done;
    logic [7:0] out_opcode;
    logic [7:0] next_out_opcode;
    logic [7:0] out_op1;
    logic [7:0] next_out_op1;
    logic [7:0] out_op2;
    logic [7:0] next_out_op2;
    logic [1:0] out_bytes;
    logic [1:0] next_out_bytes;
    logic [3:0] out_cycles;
    logic [3:0] next_out_cycles;
    logic       out_taken;
    logic       next_out_taken;
    logic       out_undef;
    logic       next_out_undef;
    logic       dwr;
    logic       next_dwr;
    logic [7:0] daddr;
    logic [7:0] next_daddr;
    logic [7:0] ddata;
    logic [7:0] next_ddata;

    // ****************************************************************
    // Execute context
    // ****************************************************************
    cit_pkg::cit_timing_type fetch_t;
    cit_pkg::cit_alu_op_type alu_op;
    logic [7:0] exec_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic       alu_cy;
    logic       alu_ac;
    logic       alu_ov;
    logic       need_byte;
    logic       step;
    logic       commit;
    logic       acc_kind;
    logic       dir_kind;

    assign fetch_t        = cit_pkg::cit_decode(code_byte_in);
    assign need_byte      = (state == cit_pkg::CIT_ST_FETCH) || (got < bytes);
    assign code_ready_out = need_byte;
    // A stalled byte freezes the cycle count
    assign step           = need_byte ? code_valid_in : 1'b1; // RULE2

    // ALU operation selected by the high nibble
    function automatic cit_pkg::cit_alu_op_type alu_sel(input logic [3:0] h);
        case (h)
            4'h2:    alu_sel = cit_pkg::CIT_ALU_ADD;
            4'h3:    alu_sel = cit_pkg::CIT_ALU_ADDC;
            4'h9:    alu_sel = cit_pkg::CIT_ALU_SUBB;
            4'h4:    alu_sel = cit_pkg::CIT_ALU_OR;
            4'h5:    alu_sel = cit_pkg::CIT_ALU_AND;
            default: alu_sel = cit_pkg::CIT_ALU_XOR;
        endcase
    endfunction : alu_sel

    always_comb begin
        exec_op  = (state == cit_pkg::CIT_ST_FETCH) ? code_byte_in : opcode;
        acc_kind = (exec_op[3:2] != 2'h0) &&
                   (exec_op[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6});
        dir_kind = (exec_op[3:1] == 3'h1) && (exec_op[7:4] inside {4'h4, 4'h5, 4'h6});
        alu_op   = alu_sel(exec_op[7:4]); // RULE1
        if (dir_kind) begin
            alu_a = src_data_in;
            alu_b = exec_op[0] ? code_byte_in : acc;
        end else begin
            alu_a = acc;
            alu_b = (exec_op[3:0] == 4'h4) ? code_byte_in : src_data_in;
        end
    end

    cit_alu u_alu (
        .a_in       (alu_a),
        .b_in       (alu_b),
        .carry_in   (flags[cit_pkg::FLAG_CY] && (alu_op != cit_pkg::CIT_ALU_ADD)),
        .op_in      (alu_op),
        .result_out (alu_res),
        .cy_out     (alu_cy),
        .ac_out     (alu_ac),
        .ov_out     (alu_ov)
    );

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb begin
        next_state      = state;
        next_opcode     = opcode;
        next_byte1      = byte1;
        next_byte2      = byte2;
        next_bytes      = bytes;
        next_cycles     = cycles;
        next_cond       = cond;
        next_taken      = taken;
        next_got        = got;
        next_cnt        = cnt;
        next_acc        = acc;
        next_flags      = flags;
        next_done       = 1'b0;
        next_out_opcode = out_opcode;
        next_out_op1    = out_op1;
        next_out_op2    = out_op2;
        next_out_bytes  = out_bytes;
        next_out_cycles = out_cycles;
        next_out_taken  = out_taken;
        next_out_undef  = out_undef;
        next_dwr        = 1'b0;
        next_daddr      = daddr;
        next_ddata      = ddata;
        commit          = 1'b0;
        case (state)
            cit_pkg::CIT_ST_FETCH: begin
                if (code_valid_in) begin
                    next_opcode = code_byte_in;
                    next_bytes  = fetch_t.bytes;
                    next_cycles = fetch_t.cycles;
                    next_cond   = fetch_t.cond;
                    next_taken  = 1'b0;
                    next_got    = 2'h1;
                    next_cnt    = 4'h1;
                    if (fetch_t.cycles == 4'h1) begin
                        commit = 1'b1; // RULE6 RULE10
                    end else begin
                        next_state = cit_pkg::CIT_ST_RUN;
                    end
                end
            end
            cit_pkg::CIT_ST_RUN: begin
                if (step) begin
                    if (need_byte) begin
                        if (got == 2'h1) begin
                            next_byte1 = code_byte_in;
                        end else begin
                            next_byte2 = code_byte_in;
                        end
                        next_got = got + 2'h1;
                        // The condition is sampled with the last program byte
                        if (cond && (got == bytes - 2'h1)) begin
                            next_taken = branch_taken_in; // RULE4
                        end
                    end
                    next_cnt = cnt + 4'h1;
                    if (cnt == next_cycles + {3'h0, next_taken} - 4'h1) begin
                        commit     = 1'b1; // RULE4
                        next_state = cit_pkg::CIT_ST_FETCH;
                    end
                end
            end
            default: next_state = cit_pkg::CIT_ST_FETCH; // RULE15
        endcase

        // Outside loads lose to an accumulator-writing commit in the same cycle: acc, and CY, AC, OV for arithmetic
        if (acc_load_in) begin
            next_acc = acc_load_data_in;
        end
        if (flags_load_in) begin
            next_flags = flags_load_data_in;
        end

        if (commit) begin
            next_done       = 1'b1;
            next_out_opcode = next_opcode;
            next_out_op1    = next_byte1;
            next_out_op2    = next_byte2;
            next_out_bytes  = next_bytes;
            next_out_cycles = next_cycles + {3'h0, next_taken};
            next_out_taken  = next_taken;
            next_out_undef  = (next_opcode == cit_pkg::UNDEF_OPCODE); // RULE5
            if (acc_kind) begin
                next_acc = alu_res; // RULE1
                if (alu_op inside {cit_pkg::CIT_ALU_ADD, cit_pkg::CIT_ALU_ADDC,
                                   cit_pkg::CIT_ALU_SUBB}) begin
                    next_flags[cit_pkg::FLAG_CY] = alu_cy;
                    next_flags[cit_pkg::FLAG_AC] = alu_ac;
                    next_flags[cit_pkg::FLAG_OV] = alu_ov;
                end
            end else if (dir_kind) begin
                next_dwr   = 1'b1; // RULE13 RULE14
                next_daddr = next_byte1;
                next_ddata = alu_res;
            end
        end
        // Parity always tracks the accumulator
        next_flags[cit_pkg::FLAG_P] = ^next_acc; // RULE1
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state      <= cit_pkg::CIT_ST_FETCH; // RULE15
            opcode     <= 8'h00;
            byte1      <= 8'h00;
            byte2      <= 8'h00;
            bytes      <= 2'h1;
            cycles     <= 4'h1;
            cond       <= 1'b0;
            taken      <= 1'b0;
            got        <= 2'h1;
            cnt        <= 4'h1;
            acc        <= cit_pkg::ACC_RESET;
            flags      <= cit_pkg::FLAGS_RESET;
            done       <= 1'b0;
            out_opcode <= 8'h00;
            out_op1    <= 8'h00;
            out_op2    <= 8'h00;
            out_bytes  <= 2'h0;
            out_cycles <= 4'h0;
            out_taken  <= 1'b0;
            out_undef  <= 1'b0;
            dwr        <= 1'b0;
            daddr      <= 8'h00;
            ddata      <= 8'h00;
        end else begin
            state      <= next_state;
            opcode     <= next_opcode;
            byte1      <= next_byte1;
            byte2      <= next_byte2;
            bytes      <= next_bytes;
            cycles     <= next_cycles;
            cond       <= next_cond;
            taken      <= next_taken;
            got        <= next_got;
            cnt        <= next_cnt;
            acc        <= next_acc;
            flags      <= next_flags;
            done       <= next_done;
            out_opcode <= next_out_opcode;
            out_op1    <= next_out_op1;
            out_op2    <= next_out_op2;
            out_bytes  <= next_out_bytes;
            out_cycles <= next_out_cycles;
            out_taken  <= next_out_taken;
            out_undef  <= next_out_undef;
            dwr        <= next_dwr;
            daddr      <= next_daddr;
            ddata      <= next_ddata;
        end
    end

    assign busy_out = (state == cit_pkg::CIT_ST_RUN);
    assign instr_done_out = done;
    assign instr_opcode_out = out_opcode;
    assign instr_operand1_out = out_op1;
    assign instr_operand2_out = out_op2;
    assign instr_bytes_out = out_bytes;
    assign instr_cycles_out = out_cycles;
    assign instr_taken_out = out_taken;
    assign instr_undefined_out = out_undef;
    assign acc_out = acc;
    assign program_status_flags_out = flags;
    assign direct_wr_out = dwr;
    assign direct_addr_out = daddr;
    assign direct_data_out = ddata;

endmodule : cit_core_timing
`default_nettype wire

/* File: testbench/cit_core_timing_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_core_timing_properties (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       code_ready_out,
    input wire logic       busy_out,
    input wire logic       instr_done_out,
    input wire logic [7:0] instr_opcode_out,
    input wire logic [1:0] instr_bytes_out,
    input wire logic [3:0] instr_cycles_out,
    input wire logic       instr_taken_out,
    input wire logic       direct_wr_out
);
    // ****************************************************************
    // Timing relations at the completion pulse, plus run length and idle after reset
    // ****************************************************************
    logic       grp;
    logic       dlog;
    logic [3:0] lo;
    assign lo   = instr_opcode_out[3:0];
    assign dlog = instr_opcode_out[7:4] inside {4'h4, 4'h5, 4'h6};
    assign grp  = dlog || (instr_opcode_out[7:4] inside {4'h2, 4'h3, 4'h9});
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_max;
        instr_done_out |-> instr_cycles_out <= 4'h8;
    endproperty
    a_max: assert property (p_max) else $error("cycle count above ceiling");
    // Stalls hold ready high, so only the locked-out stretch is bounded
    property p_busy;
        (busy_out && !code_ready_out) [*7] |=> !busy_out;
    endproperty
    a_busy: assert property (p_busy) else $error("instruction runs too long");
    property p_reg;
        instr_done_out && grp && lo[3] |-> instr_bytes_out == 2'h1 && instr_cycles_out == 4'h1;
    endproperty
    a_reg: assert property (p_reg) else $error("register form timing");
    property p_ind;
        instr_done_out && grp && lo[3:1] == 3'h3 |-> instr_bytes_out == 2'h1 && instr_cycles_out == 4'h2;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect form timing");
    property p_dirimm;
        instr_done_out && grp && lo inside {4'h4, 4'h5} |-> instr_bytes_out == 2'h2 && instr_cycles_out == 4'h2;
    endproperty
    a_dirimm: assert property (p_dirimm) else $error("direct or immediate timing");
    property p_dlog;
        instr_done_out && dlog && lo inside {4'h2, 4'h3} |-> direct_wr_out && instr_bytes_out == lo[1:0] && instr_cycles_out == lo;
    endproperty
    a_dlog: assert property (p_dlog) else $error("direct destination timing");
    property p_branch;
        instr_done_out && instr_opcode_out inside {8'h40, 8'h50, 8'h60, 8'h70} |-> instr_cycles_out == {3'h1, instr_taken_out};
    endproperty
    a_branch: assert property (p_branch) else $error("branch taken cost wrong");
    property p_reset;
        $fell(rst_in) |-> !busy_out && !instr_done_out && code_ready_out;
    endproperty
    a_reset: assert property (p_reset) else $error("not idle after reset");
endmodule : cit_core_timing_properties
bind cit_core_timing cit_core_timing_properties u_props (.clk_in, .rst_in, .code_ready_out,
    .busy_out, .instr_done_out, .instr_opcode_out, .instr_bytes_out, .instr_cycles_out,
    .instr_taken_out, .direct_wr_out);
`default_nettype wire

/* File: testbench/cit_core_timing_test.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_core_timing_test;
    logic       clk_in = 1'b0, rst_in = 1'b1, code_valid_in = 1'b0, branch_taken_in = 1'b0;
    logic       acc_load_in = 1'b0, flags_load_in = 1'b0;
    logic [7:0] code_byte_in = 8'h00, src_data_in = 8'h00;
    logic [7:0] acc_load_data_in = 8'h00, flags_load_data_in = 8'h00;
    logic       code_ready_out, busy_out, instr_done_out, instr_taken_out;
    logic       instr_undefined_out, direct_wr_out;
    logic [7:0] instr_opcode_out, instr_operand1_out, instr_operand2_out, acc_out;
    logic [7:0] program_status_flags_out, direct_addr_out, direct_data_out;
    logic [1:0] instr_bytes_out;
    logic [3:0] instr_cycles_out;
    int         fail_count = 0, num_checks = 0, ticks = 0;
    cit_core_timing uut (.clk_in, .rst_in, .code_valid_in, .code_byte_in, .code_ready_out,
        .branch_taken_in, .src_data_in, .acc_load_in, .acc_load_data_in, .flags_load_in,
        .flags_load_data_in, .busy_out, .instr_done_out, .instr_opcode_out,
        .instr_operand1_out, .instr_operand2_out, .instr_bytes_out, .instr_cycles_out,
        .instr_taken_out, .instr_undefined_out, .acc_out, .program_status_flags_out,
        .direct_wr_out, .direct_addr_out, .direct_data_out);
    always #4 clk_in = ~clk_in;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk_in) begin
        ticks++;
        if (ticks == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick
    // An idle cycle first, so valid never changes twice in one step
    task automatic exec(input logic [7:0] b0, b1, b2, input logic [1:0] nb, input logic tk,
                        input logic [7:0] src, input logic [3:0] cyc, input logic [7:0] a, f);
        logic [3:0] n;
        tick();
        code_valid_in = 1'b1;
        code_byte_in = b0;
        branch_taken_in = tk;
        src_data_in = src;
        for (int i = 1; i < nb; i++) begin
            tick();
            code_byte_in = (i == 1) ? b1 : b2;
        end
        tick();
        code_valid_in = 1'b0;
        n = {2'h0, nb};
        while (instr_done_out !== 1'b1 && n < 4'hf) begin
            tick();
            n++;
        end
        check({4'h0, n}, {4'h0, cyc});
        check(instr_opcode_out, b0);
        check({4'h0, instr_cycles_out}, {4'h0, cyc});
        check({6'h00, instr_bytes_out}, {6'h00, nb});
        check(acc_out, a);
        check(program_status_flags_out, f);
    endtask : exec
    task automatic dchk(input logic [7:0] a, input logic [7:0] d);
        check({7'h00, direct_wr_out}, 8'h01);
        check(direct_addr_out, a);
        check(instr_operand1_out, a);
        check(direct_data_out, d);
    endtask : dchk
    task automatic idle_chk;
        check({6'h00, busy_out, code_ready_out}, 8'h01);
        check({7'h00, instr_done_out}, 8'h00);
        check(acc_out, 8'h00);
        check(program_status_flags_out, 8'h00);
    endtask : idle_chk
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_arith;
        acc_load_in = 1'b1;
        acc_load_data_in = 8'h3c;
        flags_load_in = 1'b1;
        flags_load_data_in = 8'h44;
        tick();
        acc_load_in = 1'b0;
        flags_load_in = 1'b0;
        check(acc_out, 8'h3c);
        check(program_status_flags_out, 8'h44);
        exec(8'h24, 8'h05, 8'h00, 2'h2, 1'b0, 8'h00, 4'h2, 8'h41, 8'h40);
        exec(8'h28, 8'h00, 8'h00, 2'h1, 1'b0, 8'hc0, 4'h1, 8'h01, 8'h81);
        exec(8'h36, 8'h00, 8'h00, 2'h1, 1'b0, 8'h00, 4'h2, 8'h02, 8'h01);
        exec(8'h95, 8'h30, 8'h00, 2'h2, 1'b0, 8'h03, 4'h2, 8'hff, 8'hc0);
        $display("test arithmetic done");
    endtask : t_arith
    task automatic t_logic;
        exec(8'h54, 8'h0f, 8'h00, 2'h2, 1'b0, 8'h00, 4'h2, 8'h0f, 8'hc0);
        exec(8'h69, 8'h00, 8'h00, 2'h1, 1'b0, 8'h01, 4'h1, 8'h0e, 8'hc1);
        exec(8'h47, 8'h00, 8'h00, 2'h1, 1'b0, 8'h30, 4'h2, 8'h3e, 8'hc1);
        exec(8'h52, 8'h20, 8'h00, 2'h2, 1'b0, 8'hf3, 4'h2, 8'h3e, 8'hc1);
        dchk(8'h20, 8'h32);
        exec(8'h43, 8'h21, 8'h81, 2'h3, 1'b0, 8'h10, 4'h3, 8'h3e, 8'hc1);
        dchk(8'h21, 8'h91);
        check(instr_operand2_out, 8'h81);
        exec(8'h63, 8'h22, 8'hff, 2'h3, 1'b0, 8'h0f, 4'h3, 8'h3e, 8'hc1);
        dchk(8'h22, 8'hf0);
        $display("test logic done");
    endtask : t_logic
    task automatic t_long;
        exec(8'h84, 8'h00, 8'h00, 2'h1, 1'b0, 8'h00, 4'h8, 8'h3e, 8'hc1);
        exec(8'h40, 8'h05, 8'h00, 2'h2, 1'b1, 8'h00, 4'h3, 8'h3e, 8'hc1);
        check({7'h00, instr_taken_out}, 8'h01);
        exec(8'h40, 8'h05, 8'h00, 2'h2, 1'b0, 8'h00, 4'h2, 8'h3e, 8'hc1);
        check({7'h00, instr_taken_out}, 8'h00);
        exec(8'ha5, 8'h00, 8'h00, 2'h1, 1'b0, 8'h00, 4'h1, 8'h3e, 8'hc1);
        check({7'h00, instr_undefined_out}, 8'h01);
        $display("test long and branch done");
    endtask : t_long
    task automatic t_midreset;
        tick();
        code_valid_in = 1'b1;
        code_byte_in = 8'h84;
        tick();
        code_valid_in = 1'b0;
        repeat (2) tick();
        rst_in = 1'b1;
        repeat (2) tick();
        rst_in = 1'b0;
        idle_chk();
        $display("test reset in flight done");
    endtask : t_midreset
    initial begin
        repeat (16) tick();
        rst_in = 1'b0;
        idle_chk();
        t_arith();
        t_logic();
        t_long();
        t_midreset();
        stop_test();
    end
endmodule : cit_core_timing_test
`default_nettype wire
